// file: tbm_timebase.sv
// Periodic timebase: divider chain, tap select, pending flag and Avalon-MM registers
//
// Contract
// - Each overflow at the selected tap sets the pending rollover flag.
// - With interrupt enable set, a set pending flag raises the interrupt request.
// - Writing one to acknowledge clears the flag; writing zero changes nothing.
// - Acknowledge always reads zero; the pending flag is read-only.
// - Tap codes 0..7 give dividers 32768,8192,2048,128,64,32,16,8.
// - With divide-by-128 selected every divider is 128 times larger.
// - Rollover period is divider times the input clock period.
// - In wait mode counting continues; the register is not reachable.
// - In stop mode counting continues only when oscillator runs in stop.
// - Otherwise stop freezes the divider, and the register is unreachable.
// - Interrupt enable is read/write and reset to zero.
// - Enable low holds the chain at zero; reset clears enable.
// - Counting starts on enable; first event after half a period.
// - Divider clock is the oscillator clock, optionally divided by 128.
`include "tbm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tbm_timebase #(
   parameter int CNT_W = `TBM_CNT_W
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   input  wire logic [3:0]  byteenable,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // System modes and configuration
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   input  wire logic        oscillator_run_in_stop,
   input  wire logic        prescale_128_select,
   // Interrupt
   output logic             irq
);

   tbm_pkg::tbm_bus_state_t  bus_state_q;
   tbm_pkg::tbm_tap_t        tap_select_q;
   logic                     divider_run_enable_q;
   logic                     rollover_irq_enable_q;
   logic                     rollover_pending_flag_q;
   logic [`TBM_EV_W-1:0]     status_q;
   logic [`TBM_EV_W-1:0]     mask_q;
   logic [31:0]              readdata_q;
   logic [CNT_W-1:0]         count_q;
   logic                     tap_prev_q;
   logic                     cpu_ok;
   logic                     chain_live;
   logic                     acc_wr;
   logic                     wr_ctrl;
   logic                     wr_stat;
   logic                     wr_mask;
   logic                     ack_hit;
   logic [`TBM_IDX_W-1:0]    tap_bit;
   logic                     tap_level;
   logic                     rollover;
   logic [`TBM_EV_W-1:0]     events;
   tbm_pkg::tbm_tap_t        wr_tap;

   // Address decode shared by reads and writes
   function automatic logic reg_hit(input logic [`TBM_ADDR_W-1:0] a,
                                    input logic [`TBM_ADDR_W-1:0] off);
      reg_hit = (a == off);
   endfunction

   // Tap code to counter bit whose rising edge marks the rollover
   function automatic logic [`TBM_IDX_W-1:0] tap_index(input tbm_pkg::tbm_tap_t t);
      logic [`TBM_IDX_W-1:0] idx;
      idx = `TBM_TAP_IDX_0;
      unique case (t)
         3'h0: idx = `TBM_TAP_IDX_0;
         3'h1: idx = `TBM_TAP_IDX_1;
         3'h2: idx = `TBM_TAP_IDX_2;
         3'h3: idx = `TBM_TAP_IDX_3;
         3'h4: idx = `TBM_TAP_IDX_4;
         3'h5: idx = `TBM_TAP_IDX_5;
         3'h6: idx = `TBM_TAP_IDX_6;
         3'h7: idx = `TBM_TAP_IDX_7;
      endcase
      tap_index = idx;
   endfunction

   // Bus: one wait cycle, access takes effect at the edge with waitrequest low
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_state_q <= tbm_pkg::bus_idle;
      end else begin
         unique case (bus_state_q)
            tbm_pkg::bus_idle: if (read || write) begin
               bus_state_q <= tbm_pkg::bus_ack;
            end
            tbm_pkg::bus_ack: bus_state_q <= tbm_pkg::bus_idle;
         endcase
      end
   end

   assign waitrequest = (read || write) && (bus_state_q == tbm_pkg::bus_idle);

   // CPU cannot reach the register in wait or stop; accesses complete but do nothing
   assign cpu_ok  = !wait_mode && !stop_mode;
   assign acc_wr  = write && (bus_state_q == tbm_pkg::bus_ack) && cpu_ok && byteenable[0];
   assign wr_ctrl = acc_wr && reg_hit(address, `TBM_OFF_CTRL);
   assign wr_stat = acc_wr && reg_hit(address, `TBM_OFF_STAT);
   assign wr_mask = acc_wr && reg_hit(address, `TBM_OFF_MASK);
   assign ack_hit = wr_ctrl && writedata[`TBM_CTRL_ACK];
   assign wr_tap  = writedata[`TBM_CTRL_TAP_MSB:`TBM_CTRL_TAP_LSB];

   // Control fields
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         divider_run_enable_q  <= 1'b0;
         rollover_irq_enable_q <= 1'b0;
         tap_select_q          <= `TBM_TAP_RST;
      end else if (wr_ctrl) begin
         divider_run_enable_q  <= writedata[`TBM_CTRL_RUN];
         rollover_irq_enable_q <= writedata[`TBM_CTRL_IE];
         tap_select_q          <= wr_tap;
      end
   end

   // Chain advances once per oscillator cycle; stop freezes it unless oscillator stays on
   assign chain_live = divider_run_enable_q
                       && !(stop_mode && !oscillator_run_in_stop);

   tbm_div_chain #(
      .WIDTH   (CNT_W)
   ) u_chain (
      .core_clk (core_clk),
      .rst      (rst),
      .clear    (!divider_run_enable_q),
      .advance  (chain_live),
      .count_q  (count_q)
   );

   // Prescaled option moves the tap seven stages up the same chain
   assign tap_bit   = tap_index(tap_select_q)
                      + (prescale_128_select ? `TBM_PRE_SHIFT : 5'h00);
   assign tap_level = count_q[tap_bit];

   // Rising edge of the bit below the divider: first event at half period, then full period
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tap_prev_q <= 1'b0;
      end else begin
         tap_prev_q <= divider_run_enable_q ? tap_level : 1'b0;
      end
   end

   assign rollover = chain_live && tap_level && !tap_prev_q;

   // Pending flag; a rollover wins over a simultaneous acknowledge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rollover_pending_flag_q <= 1'b0;
      end else if (rollover) begin
         rollover_pending_flag_q <= 1'b1;
      end else if (ack_hit) begin
         rollover_pending_flag_q <= 1'b0;
      end
   end

   // Sticky events: rollover, and a tap rewrite while running (flags misuse)
   assign events[`TBM_EV_ROLL]   = rollover;
   assign events[`TBM_EV_TAPCHG] = wr_ctrl && divider_run_enable_q
                                   && (wr_tap != tap_select_q);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         status_q <= `TBM_EV_RST;
      end else begin
         status_q <= (status_q & ~(wr_stat ? writedata[`TBM_EV_W-1:0] : `TBM_EV_RST))
                     | events;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mask_q <= `TBM_EV_RST;
      end else if (wr_mask) begin
         mask_q <= writedata[`TBM_EV_W-1:0];
      end
   end

   assign irq = (rollover_pending_flag_q && rollover_irq_enable_q)
                || |(status_q & mask_q);

   // Read data captured in the wait cycle so it stands at the completing edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         readdata_q <= `TBM_RD_ZERO;
      end else if (read && (bus_state_q == tbm_pkg::bus_idle)) begin
         readdata_q <= `TBM_RD_ZERO;
         if (cpu_ok && reg_hit(address, `TBM_OFF_CTRL)) begin
            readdata_q[`TBM_CTRL_FLAG]                      <= rollover_pending_flag_q;
            readdata_q[`TBM_CTRL_TAP_MSB:`TBM_CTRL_TAP_LSB] <= tap_select_q;
            readdata_q[`TBM_CTRL_ACK]                       <= 1'b0;
            readdata_q[`TBM_CTRL_IE]                        <= rollover_irq_enable_q;
            readdata_q[`TBM_CTRL_RUN]                       <= divider_run_enable_q;
         end else if (cpu_ok && reg_hit(address, `TBM_OFF_STAT)) begin
            readdata_q[`TBM_EV_W-1:0] <= status_q;
         end else if (cpu_ok && reg_hit(address, `TBM_OFF_MASK)) begin
            readdata_q[`TBM_EV_W-1:0] <= mask_q;
         end
      end
   end

   assign readdata = readdata_q;

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   logic rd_done;
   assign rd_done = read && !waitrequest;

   a_flag_sets: assert property (rollover |=> rollover_pending_flag_q)
      else $error("rollover did not set pending flag");

   a_irq_follows: assert property (
      (rollover && rollover_irq_enable_q && !wr_ctrl) |=> irq)
      else $error("enabled rollover did not raise irq");

   a_ack_clears: assert property (
      (ack_hit && !rollover) |=> !rollover_pending_flag_q)
      else $error("acknowledge did not clear flag");

   a_ack_zero_keeps: assert property (
      (wr_ctrl && !writedata[`TBM_CTRL_ACK] && rollover_pending_flag_q)
      |=> rollover_pending_flag_q)
      else $error("zero acknowledge changed flag");

   a_ack_reads_zero: assert property (
      rd_done |-> !readdata[`TBM_CTRL_ACK])
      else $error("acknowledge bit read as one");

   a_first_half: assert property (
      ($rose(divider_run_enable_q) && tap_select_q == 3'h7 && !prescale_128_select
       && chain_live) ##1 (chain_live && !prescale_128_select)[*3]
      |=> rollover)
      else $error("first event not after half period");

   a_period_eight: assert property (
      (rollover && tap_select_q == 3'h7 && !prescale_128_select)
      ##1 (chain_live && $stable(tap_select_q) && !prescale_128_select)[*7]
      |=> rollover)
      else $error("rollover period not eight cycles");

   a_no_early_roll: assert property (
      (rollover && tap_select_q == 3'h7 && !prescale_128_select)
      |=> !rollover [*7])
      else $error("rollover came early");

   a_held_zero: assert property (
      !divider_run_enable_q |=> count_q == '0)
      else $error("disabled chain not at zero");

   a_stop_frozen: assert property (
      (stop_mode && !oscillator_run_in_stop) |=> $stable(count_q))
      else $error("chain moved in stop without oscillator");

   a_wait_runs: assert property (
      (chain_live && wait_mode) |=> count_q != $past(count_q))
      else $error("chain idle while enabled in wait");

   a_lowpow_locked: assert property (
      (write && !waitrequest && !cpu_ok)
      |=> $stable(tap_select_q) && $stable(rollover_irq_enable_q))
      else $error("register written in low-power mode");

   a_set_wins: assert property (
      (rollover && ack_hit) |=> rollover_pending_flag_q)
      else $error("rollover lost to acknowledge");

   c_rollover: cover property (rollover && rollover_irq_enable_q);
   c_ack: cover property (ack_hit && rollover_pending_flag_q);
   c_stop_wake: cover property (rollover && stop_mode);
   c_prescaled: cover property (rollover && prescale_128_select);

endmodule
`default_nettype wire

// file: tbm_cfg.svh
// Register map, field positions, reset values and tap constants of the timebase block
`ifndef TBM_CFG_SVH
`define TBM_CFG_SVH

`define TBM_CNT_W        22
`define TBM_IDX_W        5
`define TBM_PRE_SHIFT    5'h07

`define TBM_TAP_IDX_0    5'h0e
`define TBM_TAP_IDX_1    5'h0c
`define TBM_TAP_IDX_2    5'h0a
`define TBM_TAP_IDX_3    5'h06
`define TBM_TAP_IDX_4    5'h05
`define TBM_TAP_IDX_5    5'h04
`define TBM_TAP_IDX_6    5'h03
`define TBM_TAP_IDX_7    5'h02

`define TBM_ADDR_W       4
`define TBM_OFF_CTRL     4'h0
`define TBM_OFF_STAT     4'h4
`define TBM_OFF_MASK     4'h8

`define TBM_CTRL_FLAG    7
`define TBM_CTRL_TAP_MSB 6
`define TBM_CTRL_TAP_LSB 4
`define TBM_CTRL_ACK     3
`define TBM_CTRL_IE      2
`define TBM_CTRL_RUN     1

`define TBM_EV_W         2
`define TBM_EV_ROLL      0
`define TBM_EV_TAPCHG    1

`define TBM_TAP_RST      3'h0
`define TBM_EV_RST       2'h0
`define TBM_RD_ZERO      32'h0000_0000

`endif

// file: tbm_pkg.sv
// Types shared by the timebase block
package tbm_pkg;
   typedef logic [2:0] tbm_tap_t;
   typedef enum logic [0:0] {
      bus_idle = 1'b0,
      bus_ack  = 1'b1
   } tbm_bus_state_t;
endpackage

// file: tbm_div_chain.sv
// Divider chain counter of the timebase block
`timescale 1ns/1ps
`default_nettype none
module tbm_div_chain #(
   parameter int WIDTH = 22
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Control
   input  wire logic             clear,
   input  wire logic             advance,
   // Count
   output logic [WIDTH-1:0]      count_q
);

   // Clear has priority so a disabled chain always sits at zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         count_q <= '0;
      end else if (clear) begin
         count_q <= '0;
      end else if (advance) begin
         count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the periodic timebase block
`include "tbm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int CEIL = 90000;
   logic        core_clk, rst, read, write, wait_mode, stop_mode, osc_in_stop, pre_sel;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata, rd;
   logic        waitrequest, irq;
   int          fail_count, total_checks, cyc, seed, c, t1;
   logic [31:0] d;

   tbm_timebase i_dut (
      .core_clk(core_clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .oscillator_run_in_stop(osc_in_stop), .prescale_128_select(pre_sel), .irq(irq));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Hang guard: the longest tap alone takes about 50k cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == CEIL) begin
         fail_count = fail_count + 1;
         $display("[FAIL] run length expected %0d seen %0d", CEIL, cyc);
         results();
      end
   end

   task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_cnt(input string nm, input int lo, input int hi, input int g);
      total_checks++;
      if (g < lo || g > hi) begin
         fail_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // Request held until waitrequest is sampled low; read data taken at that edge
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] dat,
                      input logic [3:0] be);
      int k;
      @(posedge core_clk);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= dat;
      byteenable <= be;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (waitrequest !== 1'b0 && k < 20);
      if (k >= 20) begin
         fail_count++;
         $display("[FAIL] waitrequest expected 0 seen %b", waitrequest);
      end
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] dat);
      bus(1'b1, a, dat, 4'h1);
   endtask

   task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0000_0000, 4'h1);
      chk_reg(nm, e, rd);
   endtask

   function automatic logic [31:0] ctl(input logic [2:0] t, input logic ie, input logic run,
                                       input logic ack);
      return {24'h00_0000, 1'b0, t, ack, ie, run, 1'b0};
   endfunction

   function automatic int div_of(input logic [2:0] t, input logic p);
      int dv;
      case (t)
         3'h0: dv = 32768;
         3'h1: dv = 8192;
         3'h2: dv = 2048;
         3'h3: dv = 128;
         3'h4: dv = 64;
         3'h5: dv = 32;
         3'h6: dv = 16;
         default: dv = 8;
      endcase
      return p ? dv * 128 : dv;
   endfunction

   task automatic wait_irq(input int lim, output int n);
      n = 0;
      while (irq !== 1'b1 && n < lim) begin
         @(posedge core_clk);
         n++;
      end
   endtask

   // Start from a stopped chain, time first event and one full period
   task automatic run_tap(input logic [2:0] t, input logic p);
      int dv, n;
      dv = div_of(t, p);
      wreg(`TBM_OFF_CTRL, ctl(t, 1'b1, 1'b0, 1'b0));
      wreg(`TBM_OFF_CTRL, ctl(t, 1'b1, 1'b1, 1'b0));
      wait_irq(dv + 50, n);
      chk_cnt("first event", dv / 2 - 1, dv / 2 + 3, n);
      t1 = cyc;
      wreg(`TBM_OFF_CTRL, ctl(t, 1'b1, 1'b1, 1'b1));
      @(posedge core_clk);
      chk_reg("irq after ack", 32'h0, {31'h0, irq});
      wait_irq(dv + 50, n);
      chk_cnt("period", dv, dv, cyc - t1);
      wreg(`TBM_OFF_CTRL, ctl(t, 1'b0, 1'b0, 1'b1));
   endtask

   initial begin
      {read, write, wait_mode, stop_mode, osc_in_stop, pre_sel} = 6'h00;
      address = 4'h0;
      byteenable = 4'h0;
      writedata = 32'h0000_0000;
      fail_count = 0;
      total_checks = 0;
      cyc = 0;
      seed = 34740;
      rst = 1'b1;
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      chk_reg("irq at reset", 32'h0, {31'h0, irq});
      rchk("ctrl reset", `TBM_OFF_CTRL, 32'h0);
      rchk("status reset", `TBM_OFF_STAT, 32'h0);
      rchk("mask reset", `TBM_OFF_MASK, 32'h0);
      wreg(4'hc, 32'h0000_00ff);
      rchk("unmapped", 4'hc, 32'h0);
      // Random fields with the chain stopped: flag stays clear, ack reads zero
      repeat (6) begin
         d = $random(seed);
         wreg(`TBM_OFF_CTRL, {24'h00_0000, d[7:2], 2'b00});
         rchk("ctrl readback", `TBM_OFF_CTRL, {24'h0, 1'b0, d[6:4], 1'b0, d[2], 2'b00});
         bus(1'b1, `TBM_OFF_CTRL, ~d, 4'h0);
         rchk("lane off", `TBM_OFF_CTRL, {24'h0, 1'b0, d[6:4], 1'b0, d[2], 2'b00});
      end
      for (int t = 0; t < 8; t++)
         run_tap(t[2:0], 1'b0);
      pre_sel <= 1'b1;
      run_tap(3'h7, 1'b1);
      run_tap(3'h6, 1'b1);
      pre_sel <= 1'b0;
      // Ack zero keeps flag, enable gates irq, status and mask path
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b1, 1'b1, 1'b0));
      wait_irq(20, c);
      // Acknowledge lands on the edge of the next rollover: the flag must survive
      repeat (4) @(posedge core_clk);
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      rchk("set wins", `TBM_OFF_CTRL, 32'hf6);
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b0, 1'b0, 1'b0));
      rchk("ack zero", `TBM_OFF_CTRL, 32'hf0);
      chk_reg("irq gated", 32'h0, {31'h0, irq});
      rchk("status", `TBM_OFF_STAT, 32'h1);
      wreg(`TBM_OFF_MASK, 32'h1);
      @(posedge core_clk);
      chk_reg("irq masked on", 32'h1, {31'h0, irq});
      wreg(`TBM_OFF_STAT, 32'h1);
      rchk("status clear", `TBM_OFF_STAT, 32'h0);
      chk_reg("irq status off", 32'h0, {31'h0, irq});
      wreg(`TBM_OFF_MASK, 32'h0);
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b0, 1'b0, 1'b1));
      rchk("flag cleared", `TBM_OFF_CTRL, 32'h70);
      // Wait mode: chain runs, register closed
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b1, 1'b1, 1'b0));
      wait_mode <= 1'b1;
      rchk("ctrl in wait", `TBM_OFF_CTRL, 32'h0);
      wreg(`TBM_OFF_CTRL, ctl(3'h0, 1'b0, 1'b0, 1'b1));
      wait_irq(40, c);
      chk_cnt("event in wait", 0, 39, c);
      wait_mode <= 1'b0;
      rchk("ctrl after wait", `TBM_OFF_CTRL, 32'hf6);
      // Stop mode, oscillator off then on; divider left running for wakeup
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      @(posedge core_clk);
      wait_irq(20, c);
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b1, 1'b1, 1'b1));
      stop_mode <= 1'b1;
      @(posedge core_clk);
      wait_irq(64, c);
      chk_cnt("frozen in stop", 64, 64, c);
      rchk("ctrl in stop", `TBM_OFF_CTRL, 32'h0);
      osc_in_stop <= 1'b1;
      wait_irq(40, c);
      chk_cnt("wakeup in stop", 0, 39, c);
      stop_mode <= 1'b0;
      osc_in_stop <= 1'b0;
      wreg(`TBM_OFF_CTRL, ctl(3'h7, 1'b0, 1'b0, 1'b1));
      rchk("ctrl final", `TBM_OFF_CTRL, 32'h70);
      results();
   end
endmodule
`default_nettype wire
